// [core/lmi_exec.sv]
// executor for literal loads, accumulator stores, indirect store, reset and interrupt return
`timescale 1ns/1ps
`default_nettype none
module lmi_exec
	import lmi_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// return stack
	input wire logic [lmi_pkg::PC_W-1:0] stack_top_i,
	output logic stack_pop_o,
	// data memory write port
	output logic mem_we_o,
	output logic [lmi_pkg::PTR_W-1:0] mem_addr_o,
	output logic [lmi_pkg::DATA_W-1:0] mem_data_o,
	// device reset request and fetch flush
	output logic soft_reset_o,
	output logic flush_o
);
	import lmi_pkg::*;

	// ***********************************
	// registers
	// ***********************************
	logic [DATA_W-1:0] accum_q;
	logic [BANK_W-1:0] bank_q;
	logic [PAGE_W-1:0] page_q;
	logic [PTR_W-1:0] ptr_q [2];
	logic [DATA_W-1:0] irqc_q;
	logic [DATA_W-1:0] pwrc_q;
	logic [PC_W-1:0] pc_q;
	logic [15:0] opnd_q;
	lmi_state_t state_q;
	logic go;
	logic wr;
	lmi_op_t op;
	lmi_pmode_t pm;
	logic psel;
	logic rel;
	logic [PTR_W-1:0] ptr_cur;
	logic [PTR_W-1:0] ptr_new;
	logic [PTR_W-1:0] ea;
	logic busy;

	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic dec);
		// natural 16-bit wrap, no flag output
		ptr_step = dec ? PTR_W'(p - PTR_ONE) : PTR_W'(p + PTR_ONE);
	endfunction

	// ***********************************
	// command decode
	// ***********************************
	// operand word: [5:0]/[6:0]/[7:0] literal or file address, [9:8] mode,
	// [10] pointer select, [11] relative form, [5:0] signed offset when relative
	assign wr = cyc_i && stb_i && we_i && !ack_o && ce_i;
	assign busy = (state_q != ST_IDLE);
	assign go = wr && (adr_i == A_CMD) && sel_i[0] && !busy;
	assign op = lmi_op_t'(dat_i[2:0]);
	assign pm = lmi_pmode_t'(opnd_q[9:8]);
	assign psel = opnd_q[10];
	assign rel = opnd_q[11];
	assign ptr_cur = ptr_q[psel];

	always_comb begin
		ptr_new = ptr_cur;
		ea = ptr_cur;
		if (rel) begin
			// sign-extended offset, pointer itself stays
			ea = PTR_W'(ptr_cur + {{(PTR_W-OFS_W){opnd_q[OFS_W-1]}}, opnd_q[OFS_W-1:0]});
		end else begin
			case (pm)
				PM_PREINC: begin
					ptr_new = ptr_step(ptr_cur, 1'b0);
					ea = ptr_new;
				end
				PM_PREDEC: begin
					ptr_new = ptr_step(ptr_cur, 1'b1);
					ea = ptr_new;
				end
				PM_POSTINC: begin
					ptr_new = ptr_step(ptr_cur, 1'b0);
				end
				PM_POSTDEC: begin
					ptr_new = ptr_step(ptr_cur, 1'b1);
				end
				default: begin
					ptr_new = ptr_cur;
				end
			endcase
		end
	end

	// ***********************************
	// operand register
	// ***********************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opnd_q <= 16'h0000;
		end else if (wr && adr_i == A_OPND) begin
			if (sel_i[0]) opnd_q[7:0] <= dat_i[7:0];
			if (sel_i[1]) opnd_q[15:8] <= dat_i[15:8];
		end
	end

	// ***********************************
	// architectural registers
	// ***********************************
	// no status register here: none of these ops may alter flags
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_o) begin
			accum_q <= ACC_RST;
			bank_q <= BANK_RST;
			page_q <= PAGE_RST;
			ptr_q[0] <= PTR_RST;
			ptr_q[1] <= PTR_RST;
			irqc_q <= IRQC_RST;
			pc_q <= PC_RST;
		end else if (ce_i) begin
			if (go) begin
				case (op)
					OP_LDBANK: bank_q <= opnd_q[BANK_W-1:0];
					OP_LDPAGE: page_q <= opnd_q[PAGE_W-1:0];
					OP_LDACC: accum_q <= opnd_q[DATA_W-1:0];
					OP_STI: ptr_q[psel] <= ptr_new;
					OP_RETI: irqc_q[IRQ_EN_BIT] <= 1'b1;
					default: begin
					end
				endcase
			end else if (state_q == ST_RET2) begin
				pc_q <= stack_top_i;
			end else if (wr && sel_i[0]) begin
				case (adr_i)
					A_ACC: accum_q <= dat_i[DATA_W-1:0];
					A_BANK: bank_q <= dat_i[BANK_W-1:0];
					A_PAGE: page_q <= dat_i[PAGE_W-1:0];
					A_IRQC: irqc_q <= dat_i[DATA_W-1:0];
					default: begin
					end
				endcase
			end
			if (!go && wr && adr_i == A_PTR0 && sel_i[1:0] == 2'b11) begin
				ptr_q[0] <= dat_i[PTR_W-1:0];
			end
			if (!go && wr && adr_i == A_PTR1 && sel_i[1:0] == 2'b11) begin
				ptr_q[1] <= dat_i[PTR_W-1:0];
			end
		end
	end

	// soft reset clears the flag; power-on (rst_i) or a bus write to A_PWRC sets it again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwrc_q <= PWRC_RST;
		end else if (ce_i && go && op == OP_RESET) begin
			pwrc_q[SRF_BIT] <= 1'b0;
		end else if (ce_i && wr && adr_i == A_PWRC && sel_i[0]) begin
			pwrc_q <= dat_i[DATA_W-1:0];
		end
	end

	// ***********************************
	// sequencing and memory port
	// ***********************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			stack_pop_o <= 1'b0;
			flush_o <= 1'b0;
			soft_reset_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= PTR_RST;
			mem_data_o <= ACC_RST;
		end else if (ce_i) begin
			stack_pop_o <= 1'b0;
			flush_o <= 1'b0;
			soft_reset_o <= 1'b0;
			mem_we_o <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (go && op == OP_RETI) begin
						state_q <= ST_RET2;
						stack_pop_o <= 1'b1;
						flush_o <= 1'b1;
					end
				end
				ST_RET2: begin
					state_q <= ST_IDLE;
					flush_o <= 1'b1;
				end
				default: state_q <= ST_IDLE;
			endcase
			if (go && op == OP_STF) begin
				mem_we_o <= 1'b1;
				mem_addr_o <= {{(PTR_W-FADDR_W){1'b0}}, opnd_q[FADDR_W-1:0]};
				mem_data_o <= accum_q;
			end
			if (go && op == OP_STI) begin
				mem_we_o <= 1'b1;
				mem_addr_o <= ea;
				mem_data_o <= accum_q;
			end
			if (go && op == OP_RESET) begin
				soft_reset_o <= 1'b1;
			end
		end
	end

	// ***********************************
	// wishbone answer
	// ***********************************
	// one wait state: ack one cycle after the request, then dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_o <= cyc_i && stb_i && !ack_o;
			case (adr_i)
				A_OPND: dat_o <= {16'h0000, opnd_q};
				A_ACC: dat_o <= {24'h000000, accum_q};
				A_BANK: dat_o <= {26'h0000000, bank_q};
				A_PAGE: dat_o <= {25'h0000000, page_q};
				A_PTR0: dat_o <= {16'h0000, ptr_q[0]};
				A_PTR1: dat_o <= {16'h0000, ptr_q[1]};
				A_IRQC: dat_o <= {24'h000000, irqc_q};
				A_PWRC: dat_o <= {24'h000000, pwrc_q};
				A_PC: dat_o <= {17'h00000, pc_q};
				A_STAT: dat_o <= {31'h00000000, busy};
				A_STKTOP: dat_o <= {17'h00000, stack_top_i};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	property p_bank;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_LDBANK && !soft_reset_o) |=> bank_q == $past(opnd_q[BANK_W-1:0]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank literal not loaded");
	property p_page;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_LDPAGE && !soft_reset_o) |=> page_q == $past(opnd_q[PAGE_W-1:0]);
	endproperty
	a_page: assert property (p_page) else $error("page literal not loaded");
	property p_acc;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_LDACC && !soft_reset_o) |=> accum_q == $past(opnd_q[DATA_W-1:0]);
	endproperty
	a_acc: assert property (p_acc) else $error("accum literal not loaded");
	property p_stf;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_STF) |=> mem_we_o && mem_data_o == $past(accum_q);
	endproperty
	a_stf: assert property (p_stf) else $error("file store missing");
	property p_pre;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_STI && !rel && pm == PM_PREINC) |=> mem_addr_o == ptr_q[$past(psel)];
	endproperty
	a_pre: assert property (p_pre) else $error("preincrement address wrong");
	property p_post;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_STI && !rel && pm == PM_POSTDEC) |=> mem_addr_o == $past(ptr_cur);
	endproperty
	a_post: assert property (p_post) else $error("postdecrement address wrong");
	property p_rel;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_STI && rel && !soft_reset_o) |=> ptr_q[$past(psel)] == $past(ptr_cur);
	endproperty
	a_rel: assert property (p_rel) else $error("relative form moved pointer");
	property p_wrap;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_STI && !rel && pm == PM_POSTINC && ptr_cur == 16'hFFFF)
			|=> ptr_q[$past(psel)] == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
	property p_ri;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_RESET) |=> soft_reset_o && !pwrc_q[SRF_BIT];
	endproperty
	a_ri: assert property (p_ri) else $error("soft reset flag not cleared");
	property p_ret;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_RETI && ce_i) |=> stack_pop_o && flush_o ##1 flush_o && !stack_pop_o;
	endproperty
	a_ret: assert property (p_ret) else $error("return sequence wrong");
	property p_gie;
		@(posedge clk_i) disable iff (rst_i)
		(go && op == OP_RETI) |=> irqc_q[IRQ_EN_BIT];
	endproperty
	a_gie: assert property (p_gie) else $error("global enable not set");
	c_reti: cover property (@(posedge clk_i) disable iff (rst_i) go && op == OP_RETI);
	c_sti: cover property (@(posedge clk_i) disable iff (rst_i) go && op == OP_STI && rel);
	c_rst: cover property (@(posedge clk_i) disable iff (rst_i) go && op == OP_RESET);
endmodule : lmi_exec
`default_nettype wire

// [core/lmi_pkg.sv]
// package: constants and types for the literal/move/indirect/return executor
package lmi_pkg;
	// operand field and register widths
	localparam int unsigned BANK_W = 6;
	localparam int unsigned PAGE_W = 7;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FADDR_W = 7;
	localparam int unsigned PTR_W = 16;
	localparam int unsigned OFS_W = 6;
	localparam int unsigned PC_W = 15;
	// bit positions
	localparam int unsigned IRQ_EN_BIT = 7;
	localparam int unsigned SRF_BIT = 2;
	// reset values and pointer step
	localparam logic [BANK_W-1:0] BANK_RST = 6'h00;
	localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [DATA_W-1:0] IRQC_RST = 8'h00;
	localparam logic [DATA_W-1:0] PWRC_RST = 8'h04;
	localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
	// cycle counts
	localparam int unsigned RETI_CYCLES = 2;
	// wishbone offsets (byte addresses)
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_OPND = 8'h04;
	localparam logic [7:0] A_ACC = 8'h08;
	localparam logic [7:0] A_BANK = 8'h0C;
	localparam logic [7:0] A_PAGE = 8'h10;
	localparam logic [7:0] A_PTR0 = 8'h14;
	localparam logic [7:0] A_PTR1 = 8'h18;
	localparam logic [7:0] A_IRQC = 8'h1C;
	localparam logic [7:0] A_PWRC = 8'h20;
	localparam logic [7:0] A_PC = 8'h24;
	localparam logic [7:0] A_STAT = 8'h28;
	localparam logic [7:0] A_STKTOP = 8'h2C;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_LDBANK,
		OP_LDPAGE,
		OP_LDACC,
		OP_STF,
		OP_STI,
		OP_RESET,
		OP_RETI
	} lmi_op_t;

	typedef enum logic [1:0] {
		PM_PREINC,
		PM_PREDEC,
		PM_POSTINC,
		PM_POSTDEC
	} lmi_pmode_t;

	typedef enum {
		ST_IDLE,
		ST_RET2
	} lmi_state_t;
endpackage : lmi_pkg

// [test/literal_move_indirect_return_ops_tb.sv]
// testbench for the literal/move/indirect/return executor
`timescale 1ns/1ps
`default_nettype none
module literal_move_indirect_return_ops_tb;
	import lmi_pkg::*;
	// ****************
	// signals
	// ****************
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [PC_W-1:0] stack_top_i = 15'h0000;
	logic stack_pop_o, mem_we_o, soft_reset_o, flush_o;
	logic [PTR_W-1:0] mem_addr_o;
	logic [DATA_W-1:0] mem_data_o;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	int mw_n = 0, pop_n = 0, fl_n = 0, sr_n = 0;
	logic [15:0] mw_a;
	logic [7:0] mw_d;

	lmi_exec u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .soft_reset_o(soft_reset_o),
		.flush_o(flush_o));

	always #4 clk_i = ~clk_i;

	// ****************
	// monitors and timeout
	// ****************
	always @(posedge clk_i) begin
		cycles++;
		if (mem_we_o === 1'b1) begin
			mw_n++;
			mw_a = mem_addr_o;
			mw_d = mem_data_o;
		end
		if (stack_pop_o === 1'b1) pop_n++;
		if (flush_o === 1'b1) fl_n++;
		if (soft_reset_o === 1'b1) sr_n++;
		// whole run needs well under a thousand cycles
		if (cycles >= 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ****************
	// shared tasks
	// ****************
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// classic cycle: hold request until ack sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		q = dat_o;
		// one wait edge, so ack shows on the second edge
		chk("ack wait", 32'(n), 32'h2);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, q, exp);
	endtask

	task automatic cmd(input logic [2:0] op, input logic [15:0] opnd);
		wr(A_OPND, {16'h0, opnd});
		wr(A_CMD, {29'h0, op});
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_literals();
		cmd(3'd1, 16'h003F);
		rd(A_BANK, "bank", 32'h3F);
		cmd(3'd2, 16'h007F);
		rd(A_PAGE, "page", 32'h7F);
		cmd(3'd3, 16'h00FF);
		rd(A_ACC, "accum", 32'hFF);
		cmd(3'd0, 16'h0011);
		rd(A_OPND, "operand", 32'h11);
		rd(A_ACC, "accum after no-op", 32'hFF);
		rd(8'h30, "unmapped", 32'h0);
	endtask

	task automatic t_file();
		int n0;
		n0 = mw_n;
		cmd(3'd4, 16'h007F);
		chk("file we", 32'(mw_n - n0), 32'h1);
		chk("file addr", {25'h0, mw_a[6:0]}, 32'h7F);
		chk("file data", {24'h0, mw_d}, 32'hFF);
	endtask

	task automatic ind(input logic [7:0] pa, input logic [15:0] p0, input logic [15:0] op,
		input logic [15:0] ea, input logic [15:0] ep);
		int n0;
		n0 = mw_n;
		wr(pa, {16'h0, p0});
		cmd(3'd5, op);
		chk("ind we", 32'(mw_n - n0), 32'h1);
		chk("ind addr", {16'h0, mw_a}, {16'h0, ea});
		chk("ind data", {24'h0, mw_d}, 32'h5A);
		rd(pa, "pointer", {16'h0, ep});
	endtask

	task automatic t_indirect();
		cmd(3'd3, 16'h005A);
		ind(A_PTR0, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
		ind(A_PTR0, 16'h0000, 16'h0100, 16'hFFFF, 16'hFFFF);
		ind(A_PTR1, 16'hFFFF, 16'h0600, 16'hFFFF, 16'h0000);
		ind(A_PTR1, 16'h0000, 16'h0700, 16'h0000, 16'hFFFF);
		ind(A_PTR0, 16'h1000, 16'h0820, 16'h0FE0, 16'h1000);
		ind(A_PTR1, 16'h1000, 16'h0C1F, 16'h101F, 16'h1000);
		rd(A_STAT, "status", 32'h0);
	endtask

	task automatic t_return();
		stack_top_i <= 15'h2ABC;
		pop_n = 0;
		fl_n = 0;
		cmd(3'd7, 16'h0000);
		repeat (3) @(posedge clk_i);
		chk("pops", 32'(pop_n), 32'h1);
		chk("flush cycles", 32'(fl_n), 32'(RETI_CYCLES));
		rd(A_PC, "pc", 32'h2ABC);
		rd(A_STKTOP, "stack top", 32'h2ABC);
		rd(A_IRQC, "irq ctrl", 32'h80);
	endtask

	task automatic t_softreset();
		cmd(3'd3, 16'h0033);
		cmd(3'd6, 16'h0000);
		chk("reset pulses", 32'(sr_n), 32'h1);
		rd(A_PWRC, "power ctrl", 32'h0);
		rd(A_ACC, "accum after reset", 32'h0);
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_PWRC, "power ctrl reset", {24'h0, PWRC_RST});
		t_literals();
		t_file();
		t_indirect();
		t_return();
		t_softreset();
		print_verdict();
	end
endmodule // literal_move_indirect_return_ops_tb
`default_nettype wire
